/* File: rtl/pmsm_top.sv */
// Power-mode state machine: On, Off, Sleep, Standby and Coin Cell.
// Assumes comparator and pin inputs synchronous to core_clk; the register
// port stands for the serial register interface outside this block.
`timescale 1ns/1ps
// Overview of operation
// - No power-up below rising undervoltage threshold
// - Interrupt only in Sleep, Standby, On
// - Power-good reset released in On
// - On needs supply good and enable or pending auto restart
// - Supply falling in On goes Coin Cell
// - Off holds power-good low, rails minimal
// - Config 0: enable low powers off
// - Config 1: enable low over 4 s
// - Auto restart after enable power-off
// - Over-temperature forces Off until released
// - Standby follows qualified low-power request
// - Request is pin XOR invert bit
// - Request pin only acts in On
// - First power-up copies On settings
// - Effective request shown in bit 6
// - Entry delay 0 to 3 ticks
// - Three tick synchronisation of Standby
// - Sleep on enable low with mode
// - Sleep uses off set point
// - Mode bit: 0 off, 1 PFM
// - Coin Cell rejects turn-on, holds reset
// - Depleted coin cell restores all defaults
// - Thermal shutdown debounced 8 ms
module pmsm_top #(
    parameter int NUM_REGS = 3,
    parameter int LONG_PRESS_TICKS = pmsm_pkg::LONG_PRESS_TICKS,
    parameter int THERM_TICKS = pmsm_pkg::THERM_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic main_supply_above_rise,
    input wire logic main_supply_below_fall,
    input wire logic enable_pin,
    input wire logic low_power_request,
    input wire logic die_over_temp,
    input wire logic die_temp_released,
    input wire logic coin_cell_depleted,
    input wire logic fault_event,
    input wire logic turnoff_cfg,
    input wire logic long_press_off_enable,
    input wire logic auto_restart_enable,
    input wire logic [NUM_REGS-1:0] sleep_regulator_mode,
    input wire logic low_power_request_invert,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic power_good_reset_n_o,
    output logic power_good_reset_n_oe_n,
    output logic irq_out_n_o,
    output logic irq_out_n_oe_n,
    output logic core_logic_rail_en,
    output logic backup_rail_en,
    output logic regulators_on,
    output logic standby_settings_active,
    output logic [NUM_REGS-1:0] sleep_pfm,
    output logic off_setpoint_sel,
    output logic standby_copy_load,
    output logic [4:0] power_state
);
    typedef struct packed {
        logic [pmsm_pkg::TICK_W-1:0] tick_cnt;
        pmsm_pkg::pmsm_state_type state;
        logic [1:0] dly;
        logic [1:0] lp_cnt;
        logic [pmsm_pkg::LONG_W-1:0] long_cnt;
        logic [pmsm_pkg::THERM_W-1:0] therm_cnt;
        logic thermal_lock;
        logic restart_pending;
        logic cold;
        logic pg_oe_n;
        logic irq_oe_n;
        logic rails_on;
        logic low_power_request_active;
        logic [NUM_REGS-1:0] pfm;
        logic off_sel;
        logic copy_load;
        logic [7:0] rdata;
    } pmsm_top_state_type;

    localparam logic [pmsm_pkg::TICK_W-1:0] TICK_LAST =
        pmsm_pkg::TICK_W'(pmsm_pkg::TICK_CYCLES - 1);
    localparam logic [pmsm_pkg::LONG_W-1:0] LONG_LIMIT =
        pmsm_pkg::LONG_W'(LONG_PRESS_TICKS);
    localparam logic [pmsm_pkg::THERM_W-1:0] THERM_LIMIT =
        pmsm_pkg::THERM_W'(THERM_TICKS);

    generate
        if (NUM_REGS < 1 || LONG_PRESS_TICKS < 1 || THERM_TICKS < 1 ||
            LONG_PRESS_TICKS >= (1 << pmsm_pkg::LONG_W) - 1 ||
            THERM_TICKS >= (1 << pmsm_pkg::THERM_W) - 1) begin : g_bad
            $error("pmsm_top parameter out of range");
        end
    endgenerate

    function automatic logic is_active(input pmsm_pkg::pmsm_state_type s);
        is_active = (s == pmsm_pkg::ST_SLEEP) || (s == pmsm_pkg::ST_LOW_POWER_REQUEST) ||
                    (s == pmsm_pkg::ST_ON);
    endfunction

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;
    pmsm_top_state_type q;
    pmsm_top_state_type d;
    logic tick;
    logic en_s;
    logic lp_eff;
    logic long_low;
    logic therm_trip;
    logic low_power_request_go;
    logic off_req;
    logic any_mode;
    logic reg_hit;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    pmsm_sync_if #(.WIDTH(2)) sif ();
    assign sif.tick = tick;
    assign sif.ce = ce;
    assign sif.raw = {low_power_request, enable_pin};

    pmsm_sync #(
        .STAGES(pmsm_pkg::SYNC_STAGES),
        .WIDTH(2)
    ) u_sync (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .sif(sif)
    );

    assign tick = (q.tick_cnt == TICK_LAST);
    assign en_s = sif.synced[pmsm_pkg::SYNC_EN];
    assign lp_eff = sif.synced[pmsm_pkg::SYNC_LP] ^ low_power_request_invert;
    assign long_low = (q.long_cnt > LONG_LIMIT);
    assign therm_trip = (q.therm_cnt >= THERM_LIMIT);
    assign low_power_request_go = lp_eff && (q.lp_cnt >= q.dly);
    assign any_mode = |sleep_regulator_mode;
    assign off_req = !en_s &&
        (!turnoff_cfg || (long_low && long_press_off_enable));
    assign reg_hit = (reg_addr == pmsm_pkg::PWR_CTRL_ADDR);

    always_comb begin
        d = q;
        d.copy_load = 1'b0;
        d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
        if (en_s) begin
            d.long_cnt = '0;
        end else if (tick && q.long_cnt <= LONG_LIMIT) begin
            d.long_cnt = q.long_cnt + 1'b1;
        end
        if (!die_over_temp) begin
            d.therm_cnt = '0;
        end else if (tick && q.therm_cnt < THERM_LIMIT) begin
            d.therm_cnt = q.therm_cnt + 1'b1;
        end
        if (!lp_eff || q.state != pmsm_pkg::ST_ON) begin
            d.lp_cnt = 2'h0;
        end else if (tick && q.lp_cnt < q.dly) begin
            d.lp_cnt = q.lp_cnt + 2'h1;
        end
        if (reg_wr && reg_hit) begin
            d.dly = reg_wdata[pmsm_pkg::DLY_MSB:pmsm_pkg::DLY_LSB];
        end
        case (q.state)
            pmsm_pkg::ST_OFF: begin
                if (q.thermal_lock) begin
                    if (die_temp_released && !die_over_temp) begin
                        d.thermal_lock = 1'b0;
                    end
                end else if (main_supply_above_rise &&
                             (en_s || q.restart_pending)) begin
                    d.state = pmsm_pkg::ST_ON;
                    d.restart_pending = 1'b0;
                    if (q.cold) begin
                        d.copy_load = 1'b1;
                        d.cold = 1'b0;
                    end
                end
            end
            pmsm_pkg::ST_COIN: begin
                if (coin_cell_depleted) begin
                    d.cold = 1'b1;
                    d.dly = pmsm_pkg::DLY_RESET;
                    d.restart_pending = 1'b0;
                    d.thermal_lock = 1'b0;
                end else if (main_supply_above_rise) begin
                    d.state = pmsm_pkg::ST_OFF;
                end
            end
            pmsm_pkg::ST_SLEEP: begin
                if (en_s && main_supply_above_rise) begin
                    d.state = pmsm_pkg::ST_ON;
                end
            end
            pmsm_pkg::ST_LOW_POWER_REQUEST, pmsm_pkg::ST_ON: begin
                if (off_req) begin
                    if (any_mode) begin
                        d.state = pmsm_pkg::ST_SLEEP;
                    end else begin
                        d.state = pmsm_pkg::ST_OFF;
                        d.restart_pending = auto_restart_enable;
                    end
                end else if (q.state == pmsm_pkg::ST_ON && low_power_request_go) begin
                    d.state = pmsm_pkg::ST_LOW_POWER_REQUEST;
                end else if (q.state == pmsm_pkg::ST_LOW_POWER_REQUEST && !lp_eff) begin
                    d.state = pmsm_pkg::ST_ON;
                end
            end
            default: begin
                d.state = pmsm_pkg::ST_OFF;
            end
        endcase
        if (q.state != pmsm_pkg::ST_COIN && main_supply_below_fall) begin
            d.state = pmsm_pkg::ST_COIN;
            d.copy_load = 1'b0;
        end else if (therm_trip && q.state != pmsm_pkg::ST_COIN) begin
            d.state = pmsm_pkg::ST_OFF;
            d.thermal_lock = 1'b1;
            d.restart_pending = 1'b0;
            d.copy_load = 1'b0;
        end
        d.pg_oe_n = is_active(d.state);
        d.irq_oe_n = !(fault_event && is_active(d.state));
        d.rails_on = (d.state == pmsm_pkg::ST_ON) ||
                     (d.state == pmsm_pkg::ST_LOW_POWER_REQUEST);
        d.low_power_request_active = (d.state == pmsm_pkg::ST_LOW_POWER_REQUEST);
        d.off_sel = (d.state == pmsm_pkg::ST_SLEEP);
        d.pfm = (d.state == pmsm_pkg::ST_SLEEP) ?
                sleep_regulator_mode : '0;
        d.rdata = 8'h00;
        if (reg_hit) begin
            d.rdata[pmsm_pkg::LP_BIT] = lp_eff;
            d.rdata[pmsm_pkg::DLY_MSB:pmsm_pkg::DLY_LSB] = d.dly;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q <= '0;
            q.state <= pmsm_pkg::ST_OFF;
            q.dly <= pmsm_pkg::DLY_RESET;
            q.cold <= 1'b1;
            q.irq_oe_n <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign power_good_reset_n_o = 1'b0;
    assign power_good_reset_n_oe_n = q.pg_oe_n;
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe_n = q.irq_oe_n;
    assign core_logic_rail_en = rst_sync_n;
    assign backup_rail_en = rst_sync_n;
    assign regulators_on = q.rails_on;
    assign standby_settings_active = q.low_power_request_active;
    assign sleep_pfm = q.pfm;
    assign off_setpoint_sel = q.off_sel;
    assign standby_copy_load = q.copy_load;
    assign power_state = q.state;

    a_uv_fall_coin: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        ce && q.state == pmsm_pkg::ST_ON && main_supply_below_fall
        |=> q.state == pmsm_pkg::ST_COIN)
        else $error("supply fall in On did not reach Coin Cell");
    a_no_low_powerup: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state == pmsm_pkg::ST_OFF && !main_supply_above_rise
        |=> q.state != pmsm_pkg::ST_ON)
        else $error("power-up with supply below threshold");
    a_pg_off_low: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state == pmsm_pkg::ST_OFF |-> !power_good_reset_n_oe_n)
        else $error("power-good released in Off");
    a_pg_on_release: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state == pmsm_pkg::ST_ON |-> power_good_reset_n_oe_n)
        else $error("power-good held low in On");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !irq_out_n_oe_n |-> is_active(pmsm_pkg::pmsm_state_type'(q.state)))
        else $error("interrupt driven outside active states");
    a_thermal_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.thermal_lock && q.state == pmsm_pkg::ST_OFF
        |=> q.state != pmsm_pkg::ST_ON)
        else $error("turn-on accepted during thermal lock");
    a_coin_reject: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state == pmsm_pkg::ST_COIN && !main_supply_above_rise
        |=> q.state == pmsm_pkg::ST_COIN)
        else $error("Coin Cell left without supply");
    a_low_power_request_from_on: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state != pmsm_pkg::ST_ON && q.state != pmsm_pkg::ST_LOW_POWER_REQUEST
        |=> q.state != pmsm_pkg::ST_LOW_POWER_REQUEST)
        else $error("Standby entered from a state other than On");
    a_lp_reflect: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        ce && reg_hit |=> reg_rdata[pmsm_pkg::LP_BIT] == $past(lp_eff))
        else $error("effective request not reflected");
    a_sleep_pfm: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        q.state != pmsm_pkg::ST_SLEEP |-> sleep_pfm == '0)
        else $error("PFM outside Sleep");
endmodule

/* File: rtl/pmsm_pkg.sv */
// Constants, register layout and state encoding of the power-mode controller.
// Assumes a 125 MHz core clock from which a 32 kHz tick is divided.
package pmsm_pkg;
    // Power control register
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h1B;
    localparam int LP_BIT = 6;
    localparam int DLY_LSB = 4;
    localparam int DLY_MSB = 5;
    localparam logic [1:0] DLY_RESET = 2'h1;

    // Time base
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TICK_HZ = 32000;
    localparam int TICK_PERIOD_PS = 31250000;
    localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int TICK_W = 12;

    // Long press and thermal debounce, counted in 32 kHz ticks
    localparam int LONG_PRESS_MS = 4000;
    localparam int LONG_PRESS_TICKS = LONG_PRESS_MS * TICK_HZ / 1000;
    localparam int LONG_W = 18;
    localparam int THERM_DEBOUNCE_US = 8000;
    localparam int THERM_TICKS = THERM_DEBOUNCE_US * TICK_HZ / 1000000;
    localparam int THERM_W = 9;

    // Pin synchroniser depth in 32 kHz ticks
    localparam int SYNC_STAGES = 3;
    localparam int SYNC_EN = 0;
    localparam int SYNC_LP = 1;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_COIN = 5'h02,
        ST_SLEEP = 5'h04,
        ST_LOW_POWER_REQUEST = 5'h08,
        ST_ON = 5'h10
    } pmsm_state_type;
endpackage

/* File: rtl/pmsm_sync_if.sv */
// Carrier between the controller and its tick-driven pin synchroniser.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pmsm_sync_if #(parameter int WIDTH = 2);
    logic tick;
    logic ce;
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport ctrl (output tick, output ce, output raw, input synced);
    modport sync (input tick, input ce, input raw, output synced);
endinterface

/* File: rtl/pmsm_sync.sv */
// Multi-stage synchroniser that advances once per 32 kHz tick.
// Assumes tick is a one-cycle pulse of the core clock.
`timescale 1ns/1ps
module pmsm_sync #(
    parameter int STAGES = 3,
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    pmsm_sync_if.sync sif
);
    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] chain;
    } pmsm_sync_state_type;

    pmsm_sync_state_type q;
    pmsm_sync_state_type d;

    generate
        if (STAGES < 2 || WIDTH < 1) begin : g_bad
            $error("pmsm_sync needs at least two stages");
        end
    endgenerate

    always_comb begin
        d = q;
        if (sif.tick) begin
            d.chain[0] = sif.raw;
            for (int i = 1; i < STAGES; i++) begin
                d.chain[i] = q.chain[i-1];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (sif.ce) begin
            q <= d;
        end
    end

    assign sif.synced = q.chain[STAGES-1];
endmodule

/* File: sim/pmsm_host.sv */
// Host-side model that drives the enable and low-power request pins.
// Assumes push-pull pins that hold their level between calls.
`timescale 1ns/1ps
module pmsm_host (
    input wire logic clk,
    output logic enable_pin,
    output logic low_power_request
);
    initial begin
        enable_pin = 1'b0;
        low_power_request = 1'b0;
    end

    // Pins change just after an edge; callers wait out the three-tick
    // synchroniser before expecting a response
    task automatic drive(input logic en, input logic lp);
        @(posedge clk);
        enable_pin <= en;
        low_power_request <= lp;
    endtask
endmodule

/* File: sim/pmsm_top_bench.sv */
// Self-checking bench for the power-mode controller.
// Assumes the host model drives the pins and the bench drives the rest.
`timescale 1ns/1ps
module pmsm_top_bench;
    localparam int TK = pmsm_pkg::TICK_CYCLES;
    logic core_clk, rst_n, ce, sup_hi, sup_lo, over_temp, temp_rel;
    logic fault, inv, reg_wr;
    logic deplete, cfg, lp_off, restart;
    logic [2:0] mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic en_pin, lp_pin, pg_o, pg_oe_n, irq_o, irq_oe_n, core_en, bk_en;
    logic reg_on, low_power_request_act, off_sel, copy_ld;
    logic [2:0] pfm;
    logic [4:0] state;
    int num_errors = 0;
    int check_count = 0;
    int copy_cnt = 0;

    pmsm_host host (.clk(core_clk), .enable_pin(en_pin),
        .low_power_request(lp_pin));

    pmsm_top #(.LONG_PRESS_TICKS(2), .THERM_TICKS(4)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .main_supply_above_rise(sup_hi), .main_supply_below_fall(sup_lo),
        .enable_pin(en_pin), .low_power_request(lp_pin),
        .die_over_temp(over_temp), .die_temp_released(temp_rel),
        .coin_cell_depleted(deplete), .fault_event(fault),
        .turnoff_cfg(cfg), .long_press_off_enable(lp_off),
        .auto_restart_enable(restart), .sleep_regulator_mode(mode),
        .low_power_request_invert(inv), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_good_reset_n_o(pg_o), .power_good_reset_n_oe_n(pg_oe_n),
        .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n),
        .core_logic_rail_en(core_en), .backup_rail_en(bk_en),
        .regulators_on(reg_on), .standby_settings_active(low_power_request_act),
        .sleep_pfm(pfm), .off_setpoint_sel(off_sel),
        .standby_copy_load(copy_ld), .power_state(state));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (copy_ld === 1'b1) begin
            copy_cnt++;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1;
        check(reg_rdata, exp, "register read");
    endtask

    // Polls the state each cycle, bounded by lim cycles
    task automatic wait_st(input logic [4:0] s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({3'h0, state}, {3'h0, s}, "state");
    endtask

    task automatic results;
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (24 * TK) @(posedge core_clk);
        num_errors++;
        results();
    end

    initial begin
        rst_n = 1'b0; ce = 1'b1; sup_hi = 1'b0; sup_lo = 1'b0;
        over_temp = 1'b0; temp_rel = 1'b1; fault = 1'b1; inv = 1'b0;
        reg_wr = 1'b0; mode = 3'h0; reg_addr = 8'h00; reg_wdata = 8'h00;
        deplete = 1'b0; cfg = 1'b0; lp_off = 1'b0; restart = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        host.drive(1'b1, 1'b0);
        repeat (4 * TK) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_OFF, 0);
        check({7'h0, pg_oe_n}, 8'h00, "pg low in off");
        check({7'h0, irq_oe_n}, 8'h01, "irq idle in off");
        check({6'h0, core_en, bk_en}, 8'h03, "rails in off");
        check({7'h0, reg_on}, 8'h00, "regulators off");
        check({6'h0, pg_o, irq_o}, 8'h00, "open-drain data low");
        reg_read(pmsm_pkg::PWR_CTRL_ADDR, 8'h10);
        reg_read(8'h1C, 8'h00);
        @(posedge core_clk);
        sup_hi <= 1'b1;
        sup_lo <= 1'b0;
        wait_st(pmsm_pkg::ST_ON, 20);
        check({7'h0, pg_oe_n}, 8'h01, "pg released in on");
        check({7'h0, irq_oe_n}, 8'h00, "irq in on");
        check({7'h0, copy_ld}, 8'h01, "copy pulse");
        reg_write(pmsm_pkg::PWR_CTRL_ADDR, 8'h00);
        reg_read(pmsm_pkg::PWR_CTRL_ADDR, 8'h00);
        @(posedge core_clk);
        inv <= 1'b1;
        wait_st(pmsm_pkg::ST_LOW_POWER_REQUEST, 5 * TK);
        check({6'h0, reg_on, low_power_request_act}, 8'h03, "standby outputs");
        reg_read(pmsm_pkg::PWR_CTRL_ADDR, 8'h40);
        @(posedge core_clk);
        inv <= 1'b0;
        wait_st(pmsm_pkg::ST_ON, 5 * TK);
        @(posedge core_clk);
        mode <= 3'h5;
        host.drive(1'b0, 1'b0);
        wait_st(pmsm_pkg::ST_SLEEP, 5 * TK);
        check({5'h0, pfm}, 8'h05, "sleep modes");
        check({7'h0, off_sel}, 8'h01, "off set point");
        check({7'h0, irq_oe_n}, 8'h00, "irq in sleep");
        host.drive(1'b1, 1'b0);
        wait_st(pmsm_pkg::ST_ON, 5 * TK);
        @(posedge core_clk);
        ce <= 1'b0;
        sup_hi <= 1'b0;
        sup_lo <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_ON, 0);
        @(posedge core_clk);
        ce <= 1'b1;
        wait_st(pmsm_pkg::ST_COIN, 10);
        check({7'h0, pg_oe_n}, 8'h00, "pg low in coin");
        check({7'h0, irq_oe_n}, 8'h01, "irq idle in coin");
        repeat (50) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_COIN, 0);
        @(posedge core_clk);
        sup_hi <= 1'b1;
        sup_lo <= 1'b0;
        wait_st(pmsm_pkg::ST_OFF, 10);
        wait_st(pmsm_pkg::ST_ON, 10);
        check(8'(copy_cnt), 8'h01, "no second copy");
        @(posedge core_clk);
        over_temp <= 1'b1;
        temp_rel <= 1'b0;
        repeat (2 * TK) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_ON, 0);
        wait_st(pmsm_pkg::ST_OFF, 4 * TK);
        repeat (TK) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_OFF, 0);
        @(posedge core_clk);
        over_temp <= 1'b0;
        temp_rel <= 1'b1;
        wait_st(pmsm_pkg::ST_ON, 10);
        @(posedge core_clk);
        sup_hi <= 1'b0;
        sup_lo <= 1'b1;
        deplete <= 1'b1;
        wait_st(pmsm_pkg::ST_COIN, 10);
        repeat (2) @(posedge core_clk);
        deplete <= 1'b0;
        sup_hi <= 1'b1;
        sup_lo <= 1'b0;
        wait_st(pmsm_pkg::ST_ON, 10);
        check({7'h0, copy_ld}, 8'h01, "copy after depletion");
        reg_read(pmsm_pkg::PWR_CTRL_ADDR, 8'h10);
        // Long press off with a short limit, then automatic restart
        @(posedge core_clk);
        mode <= 3'h0;
        cfg <= 1'b1;
        lp_off <= 1'b1;
        restart <= 1'b1;
        host.drive(1'b0, 1'b0);
        repeat (4 * TK) @(posedge core_clk);
        #1;
        wait_st(pmsm_pkg::ST_ON, 0);
        wait_st(pmsm_pkg::ST_OFF, 3 * TK);
        wait_st(pmsm_pkg::ST_ON, 2);
        results();
    end
endmodule
